// ===== src/dmu_consts.vh
// constants of the decrement / multiply execution unit
// assumes a single 25 MHz processor clock; counts are in processor clocks
`ifndef DMU_CONSTS_VH
`define DMU_CONSTS_VH
`define DMU_OP_DEC_MEM 3'h0
`define DMU_OP_DEC_REG 3'h1
`define DMU_OP_MULU8 3'h2
`define DMU_OP_MULU16 3'h3
`define DMU_OP_MUL8 3'h4
`define DMU_OP_MUL16 3'h5
`define DMU_CLK_DEC_BYTE 6'h10
`define DMU_CLK_DEC_WORD_SLOW 6'h18
`define DMU_CLK_DEC_WORD_FAST 6'h10
`define DMU_CLK_DEC_REG 6'h02
`define DMU_CLK_MULU8_REG 6'h15
`define DMU_CLK_MULU8_MEM 6'h1B
`define DMU_CLK_MULU16_REG 6'h1D
`define DMU_CLK_MULU16_SLOW 6'h27
`define DMU_CLK_MULU16_FAST 6'h23
`define DMU_CLK_MUL8_REG 6'h21
`define DMU_CLK_MUL8_MEM 6'h27
`define DMU_CLK_MUL16_REG 6'h29
`define DMU_FLAG_CY 3'h0
`define DMU_FLAG_P 3'h1
`define DMU_FLAG_AC 3'h2
`define DMU_FLAG_Z 3'h3
`define DMU_FLAG_S 3'h4
`define DMU_FLAG_V 3'h5
`define DMU_FLAGS_RST 6'h00
`define DMU_ACC_RST 16'h0000
`endif

// ===== src/dmu_multiplier.v
// shift-add multiplier core of the decrement / multiply unit
// assumes the parent holds the operands steady between start and done
`timescale 1ns/10ps
module dmu_multiplier (
    input wire clk_in,
    input wire srst_in,
    input wire start_in,
    input wire signed_in,
    input wire word_in,
    input wire [15:0] mcand_in,
    input wire [15:0] mplier_in,
    output reg done_out,
    output reg [31:0] product_out
);
    reg [4:0] count_reg;
    reg busy_reg;
    reg [31:0] acc_reg;
    reg [31:0] cand_reg;
    reg [15:0] plier_reg;
    wire [31:0] cand_ext;
    wire [15:0] plier_mag;
    wire [31:0] cand_mag;
    wire neg_res;
    // operands are made non-negative first, the sign is restored at the end
    assign neg_res = signed_in & (word_in ? (mcand_in[15] ^ mplier_in[15])
                                          : (mcand_in[7] ^ mplier_in[7]));
    assign plier_mag = (signed_in & (word_in ? mplier_in[15] : mplier_in[7])) ?
        (word_in ? (16'h0000 - mplier_in) : {8'h00, 8'h00 - mplier_in[7:0]}) :
        (word_in ? mplier_in : {8'h00, mplier_in[7:0]});
    assign cand_ext = word_in ? {16'h0000, mcand_in} : {24'h000000, mcand_in[7:0]};
    assign cand_mag = (signed_in & (word_in ? mcand_in[15] : mcand_in[7])) ?
        (word_in ? {16'h0000, 16'h0000 - mcand_in} :
                   {24'h000000, 8'h00 - mcand_in[7:0]}) : cand_ext;
    always @(posedge clk_in) begin
        if (srst_in) begin
            count_reg <= 5'h00;
            busy_reg <= 1'b0;
            acc_reg <= 32'h00000000;
            cand_reg <= 32'h00000000;
            plier_reg <= 16'h0000;
            done_out <= 1'b0;
            product_out <= 32'h00000000;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_reg) begin
                busy_reg <= 1'b1;
                count_reg <= word_in ? 5'h10 : 5'h08;
                acc_reg <= 32'h00000000;
                cand_reg <= cand_mag;
                plier_reg <= plier_mag;
            end else if (busy_reg) begin
                if (count_reg == 5'h00) begin
                    busy_reg <= 1'b0;
                    done_out <= 1'b1;
                    product_out <= neg_res ? (32'h00000000 - acc_reg) : acc_reg;
                end else begin
                    if (plier_reg[0])
                        acc_reg <= acc_reg + cand_reg;
                    cand_reg <= {cand_reg[30:0], 1'b0};
                    plier_reg <= {1'b0, plier_reg[15:1]};
                    count_reg <= count_reg - 5'h01;
                end
            end
        end
    end
endmodule // dmu_multiplier

// ===== src/dmu_unit.v
// decrement / multiply execution unit: sequencer, flag logic, accumulator pair
// assumes the register file and bus interface answer the read/write strobes
`timescale 1ns/10ps
`include "dmu_consts.vh"
module dmu_unit (
    input wire clk_in,
    input wire srst_in,
    input wire start_in,
    input wire [2:0] op_in,
    input wire width_word_in,
    input wire fast_word_in,
    input wire [15:0] operand_in,
    input wire [15:0] acc_in,
    input wire [15:0] mem_rdata_in,
    input wire mem_rvalid_in,
    output reg busy_out,
    output reg done_out,
    output reg mem_read_out,
    output reg mem_write_out,
    output reg mem_word_out,
    output reg [15:0] mem_wdata_out,
    output reg reg_write_out,
    output reg [15:0] reg_wdata_out,
    output reg acc_write_out,
    output reg ext_write_out,
    output reg [15:0] accumulator_word_out,
    output reg [15:0] product_extension_word_out,
    output reg [5:0] flags_out,
    output reg [5:0] flags_valid_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_FETCH = 3'h1;
    localparam ST_MUL = 3'h2;
    localparam ST_PAD = 3'h3;
    localparam ST_DONE = 3'h4;
    reg [2:0] state_reg;
    reg [2:0] op_reg;
    reg word_reg;
    reg fast_reg;
    reg mem_sel_reg;
    reg [15:0] opnd_reg;
    reg [15:0] acc_reg;
    reg [5:0] cycles_reg;
    reg [5:0] target_reg;
    reg mul_start_reg;
    reg [15:0] dec_res;
    reg [5:0] dec_flags;
    wire mul_done;
    wire [31:0] mul_prod;
    wire is_mem_op;
    wire is_mul;
    wire op_word;
    wire op_signed;
    assign is_mul = (op_reg != `DMU_OP_DEC_MEM) && (op_reg != `DMU_OP_DEC_REG);
    assign op_word = (op_reg == `DMU_OP_MULU16) || (op_reg == `DMU_OP_MUL16);
    assign op_signed = (op_reg == `DMU_OP_MUL8) || (op_reg == `DMU_OP_MUL16);
    // width bit picks the memory form of a multiply; signed word stays in registers
    assign is_mem_op = (op_reg == `DMU_OP_DEC_MEM) ||
        (mem_sel_reg && (op_reg != `DMU_OP_DEC_REG) && (op_reg != `DMU_OP_MUL16));
    // data-dependent extra clocks: one for a nonzero upper multiplier region (unsigned), one per set tested operand bit (signed), bounded
    function [5:0] dmu_base_clocks;
        input [2:0] op;
        input mem;
        input fast;
        begin
            case (op)
                `DMU_OP_MULU8: dmu_base_clocks = mem ? `DMU_CLK_MULU8_MEM : `DMU_CLK_MULU8_REG;
                `DMU_OP_MULU16: dmu_base_clocks = !mem ? `DMU_CLK_MULU16_REG :
                    (fast ? `DMU_CLK_MULU16_FAST : `DMU_CLK_MULU16_SLOW);
                `DMU_OP_MUL8: dmu_base_clocks = mem ? `DMU_CLK_MUL8_MEM : `DMU_CLK_MUL8_REG;
                `DMU_OP_MUL16: dmu_base_clocks = `DMU_CLK_MUL16_REG;
                default: dmu_base_clocks = `DMU_CLK_DEC_REG;
            endcase
        end
    endfunction
    function [5:0] dmu_extra_clocks;
        input [2:0] op;
        input [15:0] a;
        input [15:0] b;
        begin
            case (op)
                `DMU_OP_MULU8: dmu_extra_clocks = {5'h00, |b[7:4]};
                `DMU_OP_MULU16: dmu_extra_clocks = {5'h00, |b[15:8]};
                `DMU_OP_MUL8, `DMU_OP_MUL16: dmu_extra_clocks =
                    {5'h00, a[15]} + {5'h00, a[7]} + {5'h00, b[15]} +
                    {5'h00, b[7]} + {5'h00, b[3]} + {5'h00, b[0]};
                default: dmu_extra_clocks = 6'h00;
            endcase
        end
    endfunction
    always @* begin
        dec_res = word_reg ? (opnd_reg - 16'h0001) : {8'h00, opnd_reg[7:0] - 8'h01};
        dec_flags = `DMU_FLAGS_RST;
        dec_flags[`DMU_FLAG_S] = word_reg ? dec_res[15] : dec_res[7];
        dec_flags[`DMU_FLAG_Z] = word_reg ? (dec_res == 16'h0000) : (dec_res[7:0] == 8'h00);
        dec_flags[`DMU_FLAG_AC] = (opnd_reg[3:0] == 4'h0);
        dec_flags[`DMU_FLAG_P] = ~^dec_res[7:0];
        dec_flags[`DMU_FLAG_V] = word_reg ? (opnd_reg == 16'h8000) : (opnd_reg[7:0] == 8'h80);
        dec_flags[`DMU_FLAG_CY] = word_reg ? (opnd_reg == 16'h0000) : (opnd_reg[7:0] == 8'h00);
    end
    dmu_multiplier u_mult (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .start_in(mul_start_reg),
        .signed_in(op_signed),
        .word_in(op_word),
        .mcand_in(acc_reg),
        .mplier_in(opnd_reg),
        .done_out(mul_done),
        .product_out(mul_prod)
    );
    always @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE;
            op_reg <= `DMU_OP_DEC_REG;
            word_reg <= 1'b0;
            fast_reg <= 1'b0;
            mem_sel_reg <= 1'b0;
            opnd_reg <= 16'h0000;
            acc_reg <= `DMU_ACC_RST;
            cycles_reg <= 6'h00;
            target_reg <= 6'h00;
            mul_start_reg <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            mem_read_out <= 1'b0;
            mem_write_out <= 1'b0;
            mem_word_out <= 1'b0;
            mem_wdata_out <= 16'h0000;
            reg_write_out <= 1'b0;
            reg_wdata_out <= 16'h0000;
            acc_write_out <= 1'b0;
            ext_write_out <= 1'b0;
            accumulator_word_out <= `DMU_ACC_RST;
            product_extension_word_out <= 16'h0000;
            flags_out <= `DMU_FLAGS_RST;
            flags_valid_out <= 6'h00;
        end else begin
            done_out <= 1'b0;
            mem_read_out <= 1'b0;
            mem_write_out <= 1'b0;
            reg_write_out <= 1'b0;
            acc_write_out <= 1'b0;
            ext_write_out <= 1'b0;
            mul_start_reg <= 1'b0;
            if (state_reg != ST_IDLE)
                cycles_reg <= cycles_reg + 6'h01;
            case (state_reg)
                ST_IDLE: begin
                    if (start_in) begin
                        op_reg <= op_in;
                        word_reg <= (op_in == `DMU_OP_DEC_REG) ? 1'b1 :
                            (op_in == `DMU_OP_MULU16) || (op_in == `DMU_OP_MUL16) ? 1'b1 :
                            (op_in == `DMU_OP_DEC_MEM) ? width_word_in : 1'b0;
                        fast_reg <= fast_word_in;
                        mem_sel_reg <= width_word_in;
                        opnd_reg <= operand_in;
                        acc_reg <= acc_in;
                        cycles_reg <= 6'h01;
                        busy_out <= 1'b1;
                        state_reg <= (op_in == `DMU_OP_DEC_REG) ? ST_PAD :
                            (op_in == `DMU_OP_DEC_MEM || op_in == `DMU_OP_MULU8 ||
                             op_in == `DMU_OP_MULU16 || op_in == `DMU_OP_MUL8) ?
                            ST_FETCH : ST_MUL;
                        target_reg <= `DMU_CLK_DEC_REG;
                    end
                end
                ST_FETCH: begin
                    // register forms pass through; memory forms wait for the read data
                    if (!is_mem_op) begin
                        state_reg <= ST_MUL;
                    end else if (mem_rvalid_in) begin
                        opnd_reg <= word_reg ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]};
                        state_reg <= is_mul ? ST_MUL : ST_PAD;
                    end else if (!mem_read_out && cycles_reg == 6'h01) begin
                        mem_read_out <= 1'b1;
                        mem_word_out <= word_reg;
                    end
                    if (op_reg == `DMU_OP_DEC_MEM)
                        target_reg <= !word_reg ? `DMU_CLK_DEC_BYTE :
                            (fast_reg ? `DMU_CLK_DEC_WORD_FAST : `DMU_CLK_DEC_WORD_SLOW);
                end
                ST_MUL: begin
                    if (!mul_start_reg && cycles_reg != 6'h00 && target_reg < 6'h08) begin
                        mul_start_reg <= 1'b1;
                        target_reg <= dmu_base_clocks(op_reg, is_mem_op, fast_reg) +
                            dmu_extra_clocks(op_reg, acc_reg, opnd_reg);
                    end
                    if (mul_done) begin
                        accumulator_word_out <= op_word ? mul_prod[15:0] : mul_prod[15:0];
                        product_extension_word_out <= op_word ? mul_prod[31:16] :
                            product_extension_word_out;
                        flags_out <= `DMU_FLAGS_RST;
                        flags_out[`DMU_FLAG_CY] <= !op_word ?
                            (op_signed ? (mul_prod[15:8] != {8{mul_prod[7]}})
                                       : (mul_prod[15:8] != 8'h00)) :
                            (op_signed ? (mul_prod[31:16] != {16{mul_prod[15]}})
                                       : (mul_prod[31:16] != 16'h0000));
                        flags_out[`DMU_FLAG_V] <= !op_word ?
                            (op_signed ? (mul_prod[15:8] != {8{mul_prod[7]}})
                                       : (mul_prod[15:8] != 8'h00)) :
                            (op_signed ? (mul_prod[31:16] != {16{mul_prod[15]}})
                                       : (mul_prod[31:16] != 16'h0000));
                        flags_valid_out <= 6'h21;
                        state_reg <= ST_PAD;
                    end
                end
                ST_PAD: begin
                    // stretch to the documented clock count, then commit
                    if (cycles_reg + 6'h01 >= target_reg) begin
                        state_reg <= ST_DONE;
                        if (!is_mul) begin
                            flags_out <= dec_flags;
                            flags_valid_out <= 6'h3F;
                            if (op_reg == `DMU_OP_DEC_MEM) begin
                                mem_write_out <= 1'b1;
                                mem_word_out <= word_reg;
                                mem_wdata_out <= dec_res;
                            end else begin
                                reg_write_out <= 1'b1;
                                reg_wdata_out <= dec_res;
                            end
                        end else begin
                            acc_write_out <= 1'b1;
                            ext_write_out <= op_word;
                        end
                    end
                end
                ST_DONE: begin
                    done_out <= 1'b1;
                    busy_out <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // dmu_unit

// ===== dv/dmu_unit_properties.sv
// concurrent checks of the decrement / multiply unit, bound onto dmu_unit
// assumes one clock clk_in and the synchronous reset srst_in of the unit
`timescale 1ns/10ps
`include "dmu_consts.vh"
module dmu_unit_properties (
    input wire clk_in,
    input wire srst_in,
    input wire start_in,
    input wire [2:0] op_in,
    input wire width_word_in,
    input wire [15:0] operand_in,
    input wire [15:0] acc_in,
    input wire busy_out,
    input wire done_out,
    input wire mem_read_out,
    input wire mem_write_out,
    input wire mem_word_out,
    input wire reg_write_out,
    input wire [15:0] reg_wdata_out,
    input wire [15:0] accumulator_word_out,
    input wire [15:0] product_extension_word_out,
    input wire [5:0] flags_out,
    input wire [5:0] flags_valid_out
);
    reg [2:0] op_q;
    reg w_q;
    reg [15:0] acc_q;
    reg [15:0] opnd_q;
    wire take = start_in && !busy_out;
    wire [15:0] u8 = acc_q[7:0] * opnd_q[7:0];
    wire [31:0] u16 = acc_q * opnd_q;
    wire signed [15:0] s8 = $signed(acc_q[7:0]) * $signed(opnd_q[7:0]);
    wire signed [31:0] s16 = $signed(acc_q) * $signed(opnd_q);
    // operands kept from the accepting edge, since inputs may move while busy
    always @(posedge clk_in) begin
        if (srst_in) begin
            op_q <= 3'h0;
            w_q <= 1'b0;
            acc_q <= 16'h0000;
            opnd_q <= 16'h0000;
        end else if (take) begin
            op_q <= op_in;
            w_q <= width_word_in;
            acc_q <= acc_in;
            opnd_q <= operand_in;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    chk_take_busy: assert property (take |=> busy_out)
        else $error("accepted start did not raise busy");
    chk_decreg_nobus: assert property (take && op_in == `DMU_OP_DEC_REG
        |=> (!mem_read_out && !mem_write_out)[*2])
        else $error("register decrement touched the bus");
    chk_decreg_time: assert property (take && op_in == `DMU_OP_DEC_REG |-> ##[1:6] done_out)
        else $error("register decrement too slow");
    chk_decreg_value: assert property (reg_write_out && op_q == `DMU_OP_DEC_REG
        |-> reg_wdata_out == opnd_q - 16'h0001)
        else $error("register decrement result wrong");
    chk_decmem_width: assert property (mem_write_out
        |-> op_q == `DMU_OP_DEC_MEM && mem_word_out == w_q)
        else $error("memory write width wrong");
    chk_mulu8_result: assert property (done_out && op_q == `DMU_OP_MULU8
        |=> accumulator_word_out == u8 && flags_out[0] == (u8[15:8] != 8'h00)
        && flags_out[5] == flags_out[0])
        else $error("unsigned byte product wrong");
    chk_mulu16_result: assert property (done_out && op_q == `DMU_OP_MULU16
        |=> {product_extension_word_out, accumulator_word_out} == u16
        && flags_out[0] == (u16[31:16] != 16'h0000) && flags_out[5] == flags_out[0])
        else $error("unsigned word product wrong");
    chk_mul8_result: assert property (done_out && op_q == `DMU_OP_MUL8
        |=> accumulator_word_out == s8 && flags_out[0] == (s8[15:8] != {8{s8[7]}})
        && flags_out[5] == flags_out[0])
        else $error("signed byte product wrong");
    chk_mul16_result: assert property (done_out && op_q == `DMU_OP_MUL16
        |=> {product_extension_word_out, accumulator_word_out} == s16
        && flags_out[0] == (s16[31:16] != {16{s16[15]}}) && flags_out[5] == flags_out[0])
        else $error("signed word product wrong");
    chk_mul_valid: assert property (done_out && op_q > `DMU_OP_DEC_REG
        |=> flags_valid_out == 6'h21)
        else $error("multiply flag validity wrong");
    chk_mul16_time: assert property (take && op_in == `DMU_OP_MUL16 |-> ##[1:50] done_out)
        else $error("signed word multiply too slow");
    cov_dec_mem: cover property (take && op_in == `DMU_OP_DEC_MEM);
    cov_mul16: cover property (take && op_in == `DMU_OP_MUL16);
    cov_carry: cover property (done_out ##1 flags_out[0]);
endmodule // dmu_unit_properties

bind dmu_unit dmu_unit_properties u_dmu_unit_properties (.clk_in(clk_in), .srst_in(srst_in),
    .start_in(start_in), .op_in(op_in), .width_word_in(width_word_in),
    .operand_in(operand_in), .acc_in(acc_in), .busy_out(busy_out), .done_out(done_out),
    .mem_read_out(mem_read_out), .mem_write_out(mem_write_out),
    .mem_word_out(mem_word_out), .reg_write_out(reg_write_out),
    .reg_wdata_out(reg_wdata_out), .accumulator_word_out(accumulator_word_out),
    .product_extension_word_out(product_extension_word_out), .flags_out(flags_out),
    .flags_valid_out(flags_valid_out));

// ===== dv/tb_top.sv
// self-checking bench of the decrement / multiply unit
// assumes the bench answers memory reads in the same cycle as the read strobe
`timescale 1ns/10ps
`include "dmu_consts.vh"
module tb_top;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic start_in = 1'b0;
    logic [2:0] op_in = 3'h0;
    logic width_word_in = 1'b0;
    logic fast_word_in = 1'b0;
    logic [15:0] operand_in = 16'h0000;
    logic [15:0] acc_in = 16'h0000;
    logic [15:0] mem_rdata_in = 16'h0000;
    logic mem_rvalid_in = 1'b0;
    wire busy_out, done_out, mem_read_out, mem_write_out, mem_word_out;
    wire reg_write_out, acc_write_out, ext_write_out;
    wire [15:0] mem_wdata_out, reg_wdata_out, accumulator_word_out, product_extension_word_out;
    wire [5:0] flags_out, flags_valid_out;
    int failures = 0;
    int compares = 0;
    always #20 clk_in = ~clk_in;
    dmu_unit u_dmu_unit (.clk_in(clk_in), .srst_in(srst_in), .start_in(start_in),
        .op_in(op_in), .width_word_in(width_word_in), .fast_word_in(fast_word_in),
        .operand_in(operand_in), .acc_in(acc_in), .mem_rdata_in(mem_rdata_in),
        .mem_rvalid_in(mem_rvalid_in), .busy_out(busy_out), .done_out(done_out),
        .mem_read_out(mem_read_out), .mem_write_out(mem_write_out),
        .mem_word_out(mem_word_out), .mem_wdata_out(mem_wdata_out),
        .reg_write_out(reg_write_out), .reg_wdata_out(reg_wdata_out),
        .acc_write_out(acc_write_out), .ext_write_out(ext_write_out),
        .accumulator_word_out(accumulator_word_out),
        .product_extension_word_out(product_extension_word_out),
        .flags_out(flags_out), .flags_valid_out(flags_valid_out));
    task automatic end_of_test;
        begin
            if (failures == 0 && compares > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        begin
            compares++;
            if (seen !== exp) begin
                failures++;
                $display("BAD %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // one operation; a poke re-strobes start while busy, which must be ignored
    task automatic do_op(input logic [2:0] op, input logic w, input logic f,
        input logic [15:0] opnd, input logic [15:0] acc, input logic [15:0] rd,
        input logic [15:0] res_e, input logic [15:0] ext_e, input logic [5:0] fl_e,
        input logic [5:0] xf_e, input int maxc, input logic poke);
        int cyc;
        int nd;
        logic [1:0] nr, nw, ng;
        logic [15:0] res;
        logic [5:0] vm;
        logic done;
        begin
            cyc = 0; nd = 0; nr = 0; nw = 0; ng = 0; res = 16'h0000; done = 1'b0;
            vm = (op > `DMU_OP_DEC_REG) ? 6'h21 : 6'h3F;
            @(negedge clk_in);
            op_in = op; width_word_in = w; fast_word_in = f;
            operand_in = opnd; acc_in = acc; start_in = 1'b1;
            @(negedge clk_in);
            while (!done) begin
                start_in = poke && (cyc == 2);
                mem_rvalid_in = mem_read_out === 1'b1;
                mem_rdata_in = (mem_read_out === 1'b1) ? rd : ~rd;
                if (mem_read_out === 1'b1) nr++;
                if (mem_write_out === 1'b1) begin
                    nw++;
                    res = mem_wdata_out;
                    check("mem width", mem_word_out, w);
                end
                if (acc_write_out === 1'b1)
                    check("ext write", ext_write_out, op == 3'h3 || op == 3'h5);
                if (reg_write_out === 1'b1) begin
                    ng++;
                    res = reg_wdata_out;
                end
                done = done_out === 1'b1;
                cyc++;
                if (cyc > 80) begin
                    failures++;
                    end_of_test();
                end
                @(negedge clk_in);
            end
            if (op > `DMU_OP_DEC_REG) res = accumulator_word_out;
            if (op == `DMU_OP_DEC_MEM && !w) res[15:8] = res_e[15:8];
            check("result", res, res_e);
            if (op == `DMU_OP_MULU16 || op == `DMU_OP_MUL16)
                check("extension", product_extension_word_out, ext_e);
            check("flags", flags_out & vm, fl_e & vm);
            check("flag validity", flags_valid_out, vm);
            check("transfers", {nr, nw, ng}, xf_e);
            check("clocks", cyc + 1 <= maxc, 1);
            repeat (3) begin
                @(negedge clk_in);
                if (done_out === 1'b1) nd++;
            end
            check("extra done", nd, 0);
        end
    endtask
    task automatic t_dec_reg;
        begin
            do_op(3'h1, 0, 0, 16'h0001, 0, 0, 16'h0000, 0, 6'h0A, 6'h01, 6, 0);
            do_op(3'h1, 0, 0, 16'h0000, 0, 0, 16'hFFFF, 0, 6'h17, 6'h01, 6, 0);
            do_op(3'h1, 0, 0, 16'h8000, 0, 0, 16'h7FFF, 0, 6'h26, 6'h01, 6, 0);
        end
    endtask
    task automatic t_dec_mem;
        begin
            do_op(3'h0, 0, 0, 0, 0, 16'h1200, 16'h00FF, 0, 6'h17, 6'h14, 20, 0);
            do_op(3'h0, 1, 1, 0, 0, 16'h8000, 16'h7FFF, 0, 6'h26, 6'h14, 20, 0);
            do_op(3'h0, 1, 0, 0, 0, 16'h0010, 16'h000F, 0, 6'h06, 6'h14, 28, 0);
        end
    endtask
    task automatic t_mulu8;
        begin
            do_op(3'h2, 0, 0, 16'h0005, 16'hAA0D, 0, 16'h0041, 0, 6'h00, 0, 26, 0);
            do_op(3'h2, 0, 0, 16'h0014, 16'h5523, 0, 16'h02BC, 0, 6'h21, 0, 26, 0);
            do_op(3'h2, 0, 0, 16'h33FF, 16'h00FF, 0, 16'hFE01, 0, 6'h21, 0, 26, 0);
            do_op(3'h2, 1, 0, 16'h0014, 16'h5523, 16'h0014, 16'h02BC, 0, 6'h21, 6'h10, 30, 0);
        end
    endtask
    task automatic t_mulu16;
        begin
            do_op(3'h3, 0, 0, 16'h0003, 16'h1234, 0, 16'h369C, 16'h0000, 0, 0, 34, 0);
            do_op(3'h3, 0, 0, 16'h9310, 16'h0400, 0, 16'h4000, 16'h024C, 6'h21, 0, 34, 0);
            do_op(3'h3, 0, 0, 16'hFFFF, 16'hFFFF, 0, 16'h0001, 16'hFFFE, 6'h21, 0, 34, 0);
            do_op(3'h3, 1, 1, 16'h9310, 16'h0400, 16'h9310, 16'h4000, 16'h024C, 6'h21, 6'h10,
                38, 0);
        end
    endtask
    task automatic t_mul8;
        begin
            do_op(3'h4, 0, 0, 16'h00FE, 16'h3312, 0, 16'hFFDC, 0, 6'h00, 0, 43, 0);
            do_op(3'h4, 0, 0, 16'h00FC, 16'h0064, 0, 16'hFE70, 0, 6'h21, 0, 43, 0);
            do_op(3'h4, 0, 0, 16'h0080, 16'h0080, 0, 16'h4000, 0, 6'h21, 0, 43, 0);
            do_op(3'h4, 1, 0, 16'h00FC, 16'h0064, 16'h00FC, 16'hFE70, 0, 6'h21, 6'h10, 47, 0);
        end
    endtask
    task automatic t_mul16;
        begin
            do_op(3'h5, 0, 0, 16'hFFF6, 16'hFFF6, 0, 16'h0064, 16'h0000, 0, 0, 51, 0);
            do_op(3'h5, 0, 0, 16'h0002, 16'h7FFF, 0, 16'hFFFE, 16'h0000, 6'h21, 0, 51, 1);
        end
    endtask
    initial begin
        repeat (3) @(negedge clk_in);
        srst_in = 1'b0;
        check("after reset", {busy_out, done_out, flags_valid_out}, 0);
        t_dec_reg();
        t_dec_mem();
        t_mulu8();
        t_mulu16();
        t_mul8();
        t_mul16();
        end_of_test();
    end
endmodule // tb_top
